// ===== verilog/ocpu_pkg.sv
// Package of constants and types for the output compare PWM unit
package ocpu_pkg;

  localparam int unsigned TMR_W = 16;

  // Control settings in the low three bits of the control register
  localparam logic [2:0] MODE_OFF      = 3'h0;
  localparam logic [2:0] MODE_HIGH     = 3'h1;
  localparam logic [2:0] MODE_LOW      = 3'h2;
  localparam logic [2:0] MODE_TOGGLE   = 3'h3;
  localparam logic [2:0] MODE_PWM      = 3'h6;

  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] DUTY_RESET  = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;

  // One instruction cycle is one clock of ref_clk_i
  localparam int unsigned GLITCH_CYCLES = 1;

  typedef enum logic [1:0] {
    OCPU_IDLE  = 2'b00,
    OCPU_RUN   = 2'b01,
    OCPU_SKIP  = 2'b10,
    OCPU_DONE  = 2'b11
  } ocpu_state_t;

endpackage : ocpu_pkg

// ===== verilog/ocpu_ctl_if.sv
// Interface carrying timer events between the timer and the compare core
`timescale 1ns/1ps
`default_nettype none
interface ocpu_ctl_if;
  logic [15:0] count;
  logic        period_start;

  modport tmr  (output count, output period_start);
  modport core (input  count, input  period_start);
endinterface : ocpu_ctl_if
`default_nettype wire

// ===== verilog/ocpu_timer.sv
// Free running period timer feeding the compare core
`timescale 1ns/1ps
`default_nettype none
module ocpu_timer (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] period_i,
  ocpu_ctl_if.tmr          ev
);

  typedef struct packed {
    logic [15:0] count;
    logic        start;
  } ocpu_tmr_t;

  ocpu_tmr_t st_r;
  ocpu_tmr_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (st_r.count >= period_i) begin
      st_nxt.count = 16'h0000;
      st_nxt.start = 1'b1;
    end else begin
      st_nxt.count = st_r.count + 16'h0001;
      st_nxt.start = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ev.count        = st_r.count;
  assign ev.period_start = st_r.start;

endmodule : ocpu_timer
`default_nettype wire

// ===== verilog/ocpu_top.sv
// Output compare unit with PWM mode, modelling this revision's glitches
// What this block does
// - Zero duty gives one-cycle high glitch
// - After glitch, next compare is skipped
// - Settings 2 and 3 drive pin low at once
// - Enable from high pin pulses low once
`timescale 1ns/1ps
`default_nettype none
module ocpu_top (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] compare_control_register_i,
  input  wire logic [15:0] duty_cycle_register_i,
  input  wire logic [15:0] compare_value_i,
  input  wire logic [15:0] period_i,
  input  wire logic        port_latch_i,
  output logic             oc_pin_o,
  output logic             oc_pin_oe_o
);

  ocpu_ctl_if ev ();

  ocpu_timer u_timer (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .period_i  (period_i),
    .ev        (ev.tmr)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ocpu_pkg::ocpu_state_t state;
    logic [2:0]            mode;
    logic                  pin;
    logic                  oe;
    logic                  skip;
    logic                  glitch;
  } ocpu_st_t;

  ocpu_st_t st_r;
  ocpu_st_t st_nxt;

  logic [2:0] mode_req;
  logic       pin_before;
  logic       match;

  assign mode_req   = compare_control_register_i[2:0];
  assign pin_before = st_r.oe ? st_r.pin : port_latch_i;
  assign match      = (ev.count == compare_value_i);

  function automatic logic is_low_mode(input logic [2:0] m);
    is_low_mode = (m == ocpu_pkg::MODE_LOW) || (m == ocpu_pkg::MODE_TOGGLE);
  endfunction : is_low_mode

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.mode   = mode_req;
    st_nxt.glitch = 1'b0;
    if (mode_req == ocpu_pkg::MODE_OFF) begin
      // Off releases the pin to the port latch; the skip is also cleared
      st_nxt.state = ocpu_pkg::OCPU_IDLE;
      st_nxt.oe    = 1'b0;
      st_nxt.pin   = port_latch_i;
      st_nxt.skip  = 1'b0;
    end else if (st_r.mode != mode_req) begin
      // A new mode starts clean, so a stale skip cannot eat a later period
      st_nxt.state = ocpu_pkg::OCPU_RUN;
      st_nxt.oe    = 1'b1;
      st_nxt.skip  = 1'b0;
      if (is_low_mode(mode_req) && pin_before) begin
        st_nxt.pin    = 1'b0;
        st_nxt.glitch = 1'b1;
      end else begin
        st_nxt.pin = pin_before;
      end
    end else if (st_r.glitch && is_low_mode(st_r.mode)) begin
      // Pulse lasts one cycle, then the pin returns high until the match
      st_nxt.pin = 1'b1;
    end else begin
      unique case (st_r.state)
        ocpu_pkg::OCPU_IDLE: st_nxt.state = ocpu_pkg::OCPU_RUN;
        ocpu_pkg::OCPU_RUN: begin
          if (st_r.mode == ocpu_pkg::MODE_PWM) begin
            if (ev.period_start) begin
              if (duty_cycle_register_i == 16'h0000) begin
                st_nxt.pin  = 1'b1;
                st_nxt.skip = 1'b1;
              end else if (st_r.skip) begin
                st_nxt.pin  = 1'b0;
                st_nxt.skip = 1'b0;
              end else begin
                st_nxt.pin = 1'b1;
              end
            end else if (st_r.skip) begin
              st_nxt.pin = 1'b0;
            end else if (ev.count == duty_cycle_register_i) begin
              st_nxt.pin = 1'b0;
            end
          end else if (match) begin
            unique case (st_r.mode)
              ocpu_pkg::MODE_HIGH: begin
                st_nxt.pin   = 1'b1;
                st_nxt.state = ocpu_pkg::OCPU_DONE;
              end
              ocpu_pkg::MODE_LOW: begin
                st_nxt.pin   = 1'b0;
                st_nxt.state = ocpu_pkg::OCPU_DONE;
              end
              ocpu_pkg::MODE_TOGGLE: st_nxt.pin = ~st_r.pin;
              default: st_nxt.pin = st_r.pin;
            endcase
          end
        end
        ocpu_pkg::OCPU_SKIP: st_nxt.state = ocpu_pkg::OCPU_RUN;
        ocpu_pkg::OCPU_DONE: st_nxt.state = ocpu_pkg::OCPU_DONE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign oc_pin_o    = st_r.pin;
  assign oc_pin_oe_o = st_r.oe;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Zero duty: one high cycle, then low unless the mode moved on or a wrap came
  sequence s_glitch_high;
    oc_pin_o;
  endsequence

  sequence s_glitch_end;
    !oc_pin_o || st_r.mode != ocpu_pkg::MODE_PWM || $past(ev.period_start);
  endsequence

  // Enable into a drive-low mode: one low cycle, then high unless the mode moved on
  sequence s_pulse_low;
    !oc_pin_o && oc_pin_oe_o;
  endsequence

  sequence s_pulse_back;
    oc_pin_o || st_r.mode != $past(st_r.mode);
  endsequence

  property p_zero_glitch;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (st_r.mode == ocpu_pkg::MODE_PWM && mode_req == ocpu_pkg::MODE_PWM && !st_r.glitch
       && ev.period_start && duty_cycle_register_i == 16'h0000)
      |=> s_glitch_high ##1 s_glitch_end;
  endproperty
  a_zero_glitch: assert property (p_zero_glitch) else $error("zero duty glitch wrong");

  property p_skip;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (st_r.skip && st_r.mode == ocpu_pkg::MODE_PWM && mode_req == ocpu_pkg::MODE_PWM
       && ev.period_start && duty_cycle_register_i != 16'h0000) |=> !oc_pin_o;
  endproperty
  a_skip: assert property (p_skip) else $error("compare not skipped");

  property p_pwm_rise;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (st_r.mode == ocpu_pkg::MODE_PWM && mode_req == ocpu_pkg::MODE_PWM && !st_r.skip
       && ev.period_start && duty_cycle_register_i != 16'h0000) |=> oc_pin_o;
  endproperty
  a_pwm_rise: assert property (p_pwm_rise) else $error("pwm did not rise");

  property p_enable_pulse;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (st_r.mode == ocpu_pkg::MODE_OFF && mode_req == ocpu_pkg::MODE_LOW && port_latch_i)
      |=> s_pulse_low ##1 s_pulse_back;
  endproperty
  a_enable_pulse: assert property (p_enable_pulse) else $error("enable pulse wrong");

  property p_low_match;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (st_r.state == ocpu_pkg::OCPU_RUN && st_r.mode == ocpu_pkg::MODE_LOW
       && mode_req == ocpu_pkg::MODE_LOW && !st_r.glitch && match) |=> !oc_pin_o;
  endproperty
  a_low_match: assert property (p_low_match) else $error("low mode missed match");

  property p_pwm_fall;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (st_r.mode == ocpu_pkg::MODE_PWM && mode_req == ocpu_pkg::MODE_PWM && !st_r.skip
       && !ev.period_start && ev.count == duty_cycle_register_i) |=> !oc_pin_o;
  endproperty
  a_pwm_fall: assert property (p_pwm_fall) else $error("pwm did not fall at duty");

  property p_skip_hold;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (st_r.skip && st_r.mode == ocpu_pkg::MODE_PWM && mode_req == ocpu_pkg::MODE_PWM
       && !ev.period_start) |=> !oc_pin_o;
  endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("skipped period not low");

  property p_enable_from_high;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (st_r.mode == ocpu_pkg::MODE_HIGH && oc_pin_o && oc_pin_oe_o
       && is_low_mode(mode_req)) |=> s_pulse_low ##1 s_pulse_back;
  endproperty
  a_enable_from_high: assert property (p_enable_from_high) else $error("pulse from high wrong");

  property p_toggle_match;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (st_r.state == ocpu_pkg::OCPU_RUN && st_r.mode == ocpu_pkg::MODE_TOGGLE
       && mode_req == ocpu_pkg::MODE_TOGGLE && !st_r.glitch && match)
      |=> oc_pin_o != $past(oc_pin_o);
  endproperty
  a_toggle_match: assert property (p_toggle_match) else $error("toggle missed match");

endmodule : ocpu_top
`default_nettype wire

// ===== dv/ocpu_top_tb_top.sv
// Self-checking testbench for the output compare PWM unit
`timescale 1ns/1ps
`default_nettype none
module ocpu_top_tb_top;
  logic        ref_clk_i  = 1'b0;
  logic        sys_rst_i  = 1'b1;
  logic [15:0] ctrl       = 16'h0000;
  logic [15:0] duty       = 16'h0000;
  logic        latch      = 1'b0;
  logic        pin;
  logic        oe;
  int          fail_count = 0;
  int          compares   = 0;
  logic [15:0] h4;
  logic [15:0] h;
  logic [15:0] tr;

  always #4 ref_clk_i = ~ref_clk_i;

  // Period of 16 cycles keeps every window short
  ocpu_top dut_u (
    .ref_clk_i                  (ref_clk_i),
    .sys_rst_i                  (sys_rst_i),
    .compare_control_register_i (ctrl),
    .duty_cycle_register_i      (duty),
    .compare_value_i            (16'h000A),
    .period_i                   (16'h000F),
    .port_latch_i               (latch),
    .oc_pin_o                   (pin),
    .oc_pin_oe_o                (oe)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic wrap_up;
    $display("fails=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic set_cfg(input logic [2:0] m, input logic [15:0] d, input logic l);
    @(posedge ref_clk_i);
    ctrl  <= {13'h0000, m};
    duty  <= d;
    latch <= l;
  endtask : set_cfg

  // Counts high samples and level changes over n cycles
  task automatic watch(input int n);
    logic last;
    h  = 16'h0000;
    tr = 16'h0000;
    @(negedge ref_clk_i);
    last = pin;
    repeat (n) begin
      @(negedge ref_clk_i);
      h += {15'h0000, pin};
      if (pin !== last) tr++;
      last = pin;
    end
  endtask : watch

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_pwm;
    set_cfg(ocpu_pkg::MODE_PWM, 16'h0004, 1'b0);
    repeat (40) @(posedge ref_clk_i);
    watch(16);
    h4 = h;
    chk(tr, 16'h0002);
    chk(h4, 16'h0004);
    set_cfg(ocpu_pkg::MODE_PWM, 16'h0009, 1'b0);
    repeat (40) @(posedge ref_clk_i);
    watch(16);
    chk(h, 16'h0009);
  endtask : t_pwm

  task automatic t_zero;
    int i;
    set_cfg(ocpu_pkg::MODE_PWM, 16'h0000, 1'b0);
    repeat (40) @(posedge ref_clk_i);
    watch(16);
    chk(h, 16'h0001);
    // Catch a glitch, then ask for duty 6 right behind it
    i = 0;
    while (pin !== 1'b1 && i < 40) begin
      @(negedge ref_clk_i);
      i++;
    end
    if (i == 40) begin
      fail_count++;
      wrap_up();
    end
    @(posedge ref_clk_i);
    duty <= 16'h0006;
    watch(30);
    chk(h, 16'h0000);
    watch(16);
    chk(h, 16'h0006);
  endtask : t_zero

  task automatic t_enable(input logic [2:0] m, input logic [15:0] edges);
    set_cfg(ocpu_pkg::MODE_OFF, 16'h0000, 1'b1);
    repeat (8) @(posedge ref_clk_i);
    set_cfg(m, 16'h0000, 1'b1);
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk({15'h0000, oe}, 16'h0001);
    chk({15'h0000, pin}, 16'h0000);
    @(negedge ref_clk_i);
    chk({15'h0000, pin}, 16'h0001);
    watch(32);
    chk(tr, edges);
  endtask : t_enable

  // Pin driven high by the unit itself, then a drive-low mode is chosen
  task automatic t_high;
    set_cfg(ocpu_pkg::MODE_OFF, 16'h0000, 1'b0);
    repeat (4) @(posedge ref_clk_i);
    set_cfg(ocpu_pkg::MODE_HIGH, 16'h0000, 1'b0);
    watch(32);
    chk(tr, 16'h0001);
    chk({15'h0000, pin}, 16'h0001);
    set_cfg(ocpu_pkg::MODE_LOW, 16'h0000, 1'b0);
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk({14'h0000, oe, pin}, 16'h0002);
    @(negedge ref_clk_i);
    chk({15'h0000, pin}, 16'h0001);
    watch(16);
    chk(tr, 16'h0001);
  endtask : t_high

  // Zero duty is served by switching off, then PWM resumes cleanly
  task automatic t_off;
    set_cfg(ocpu_pkg::MODE_PWM, 16'h0000, 1'b0);
    repeat (20) @(posedge ref_clk_i);
    set_cfg(ocpu_pkg::MODE_OFF, 16'h0000, 1'b0);
    repeat (4) @(posedge ref_clk_i);
    watch(16);
    chk(h, 16'h0000);
    chk({15'h0000, oe}, 16'h0000);
    set_cfg(ocpu_pkg::MODE_OFF, 16'h0000, 1'b1);
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk({14'h0000, oe, pin}, 16'h0001);
    set_cfg(ocpu_pkg::MODE_PWM, 16'h0006, 1'b0);
    repeat (40) @(posedge ref_clk_i);
    watch(16);
    chk(h, 16'h0006);
  endtask : t_off

  initial begin
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(negedge ref_clk_i);
    chk({14'h0000, oe, pin}, 16'h0000);
    t_pwm();
    t_zero();
    t_enable(ocpu_pkg::MODE_LOW, 16'h0001);
    t_enable(ocpu_pkg::MODE_TOGGLE, 16'h0002);
    t_high();
    t_off();
    wrap_up();
  end
endmodule : ocpu_top_tb_top
`default_nettype wire
